/* File: sfl_cfg.svh */
// constants of the shared fault line response block
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH

`define SFL_CLK_PERIOD_NS 40
`define SFL_PERSIST_NS 10000
`define SFL_PERSIST_CYCLES ((`SFL_PERSIST_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS)
`define SFL_CNT_W 9
`define SFL_NUM_LINES 4
`define SFL_NUM_CHAN 8
`define SFL_CHAN_PER_ZONE 4
`define SFL_SEL_W 4

`define SFL_ADR_W 8
`define SFL_ADR_Z0_LINE_A 8'h00
`define SFL_ADR_Z0_LINE_B 8'h04
`define SFL_ADR_Z1_LINE_A 8'h08
`define SFL_ADR_Z1_LINE_B 8'h0c
`define SFL_ADR_STATUS 8'h10
`define SFL_ADR_LIVE 8'h14
`define SFL_ADR_WORD_MASK 8'hfc

`define SFL_SEL_RESET 4'h0
`define SFL_STATUS_RESET 8'h00
`define SFL_DAT_ZERO 32'h0000_0000

`endif

/* File: sfl_pkg.sv */
// types shared by the shared fault line response block
`default_nettype none
package sfl_pkg;

   typedef enum logic [2:0] {
      SFL_IDLE = 3'h1,
      SFL_WAIT = 3'h2,
      SFL_HELD = 3'h4
   } sfl_line_state_t;

   typedef struct packed {
      logic asserted;
      logic held;
   } sfl_line_status_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } sfl_wb_req_t;

endpackage
`default_nettype wire

/* File: sfl_line_qualifier.sv */
// synchroniser and persistence timer for one shared fault line
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"

module sfl_line_qualifier (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic line_n_i,
   output sfl_pkg::sfl_line_status_t status_o
);

   logic sync1;
   logic sync2;
   logic sync3;
   logic line_low;
   logic [`SFL_CNT_W-1:0] cnt;
   sfl_pkg::sfl_line_state_t state;

   // lines idle high, so reset to the released level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
      end else begin
         sync1 <= line_n_i;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_low <= 1'b0;
      end else if (sync2 == sync3) begin
         line_low <= ~sync3;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= sfl_pkg::SFL_IDLE;
         cnt <= '0;
      end else begin
         case (state)
            sfl_pkg::SFL_IDLE: begin
               cnt <= '0;
               if (line_low) begin
                  state <= sfl_pkg::SFL_WAIT;
               end
            end
            sfl_pkg::SFL_WAIT: begin
               if (!line_low) begin
                  state <= sfl_pkg::SFL_IDLE;
                  cnt <= '0;
               end else if (cnt == `SFL_CNT_W'(`SFL_PERSIST_CYCLES - 1)) begin
                  state <= sfl_pkg::SFL_HELD;
               end else begin
                  cnt <= cnt + `SFL_CNT_W'(1);
               end
            end
            sfl_pkg::SFL_HELD: begin
               if (!line_low) begin
                  state <= sfl_pkg::SFL_IDLE;
               end
            end
            default: begin
               state <= sfl_pkg::SFL_IDLE;
               cnt <= '0;
            end
         endcase
      end
   end

   assign status_o.asserted = line_low;
   assign status_o.held = (state == sfl_pkg::SFL_HELD);

endmodule
`default_nettype wire

/* File: sfl_fault_response.sv */
// shared fault line response: shutdown select registers, channel gating, status and alert
// Operation
// - zone 0 registers pick which of channels 0-3 shut off on their line.
// - zone 1 registers pick which of channels 4-7 shut off on their line.
// - a fault-line shutdown drives the alert output low.
// - a fault-line shutdown sets the channel's bit in the status register.
// - upper four bits of each select register read zero and ignore writes.
// - select bit zero keeps the channel running whatever the line does.
// - select bit one shuts the channel if the line is still low after 10us.
// - channel restarts through its normal turn-on sequence once the line releases.
// - zone 0 select bit n controls channel n.
// - zone 1 select bit n controls channel n plus four.
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"

module sfl_fault_response (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic zone0_fault_line_a_n_i,
   input wire logic zone0_fault_line_b_n_i,
   input wire logic zone1_fault_line_a_n_i,
   input wire logic zone1_fault_line_b_n_i,
   output logic [7:0] chan_off_o,
   output logic [7:0] chan_restart_o,
   output logic alert_out_n_o
);

   sfl_pkg::sfl_wb_req_t req;
   sfl_pkg::sfl_line_status_t line_status [`SFL_NUM_LINES];
   logic [`SFL_NUM_LINES-1:0] line_n;
   logic [`SFL_NUM_LINES-1:0] line_held;
   logic [`SFL_NUM_LINES-1:0] line_low;
   logic [`SFL_SEL_W-1:0] shutdown_select [`SFL_NUM_LINES];
   logic [`SFL_NUM_CHAN-1:0] chan_off;
   logic [`SFL_NUM_CHAN-1:0] next_chan_off;
   logic [`SFL_NUM_CHAN-1:0] status_mfr;
   logic [`SFL_NUM_CHAN-1:0] status_clear;
   logic [`SFL_NUM_CHAN-1:0] shut_event;
   logic bus_take;
   logic bus_write;
   logic [`SFL_ADR_W-1:0] word_adr;
   logic [31:0] next_rdata;

   // line index: bit 1 is the zone, bit 0 picks line a or b
   assign line_n[0] = zone0_fault_line_a_n_i;
   assign line_n[1] = zone0_fault_line_b_n_i;
   assign line_n[2] = zone1_fault_line_a_n_i;
   assign line_n[3] = zone1_fault_line_b_n_i;

   genvar gl;
   generate
      for (gl = 0; gl < `SFL_NUM_LINES; gl = gl + 1) begin : g_line
         sfl_line_qualifier u_qual (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .line_n_i(line_n[gl]),
            .status_o(line_status[gl])
         );
         assign line_held[gl] = line_status[gl].held;
         assign line_low[gl] = line_status[gl].asserted;
      end
   endgenerate

   // a line reaches only the four channels of its own zone
   function automatic logic line_hits(input int line, input int chan,
                                      input logic [`SFL_SEL_W-1:0] sel);
      logic in_zone;
      in_zone = ((line / 2) == (chan / `SFL_CHAN_PER_ZONE));
      line_hits = in_zone && sel[chan % `SFL_CHAN_PER_ZONE];
   endfunction

   // maps a word address to a select register index, or -1 if none
   function automatic int select_index(input logic [`SFL_ADR_W-1:0] adr);
      case (adr)
         `SFL_ADR_Z0_LINE_A: select_index = 0;
         `SFL_ADR_Z0_LINE_B: select_index = 1;
         `SFL_ADR_Z1_LINE_A: select_index = 2;
         `SFL_ADR_Z1_LINE_B: select_index = 3;
         default: select_index = -1;
      endcase
   endfunction

   genvar gc;
   generate
      for (gc = 0; gc < `SFL_NUM_CHAN; gc = gc + 1) begin : g_chan
         always_comb begin
            next_chan_off[gc] = 1'b0;
            for (int l = 0; l < `SFL_NUM_LINES; l++) begin
               // a clear select bit never gates the channel
               if (line_held[l] && line_hits(l, gc, shutdown_select[l])) begin
                  next_chan_off[gc] = 1'b1;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_off <= '0;
      end else begin
         chan_off <= next_chan_off;
      end
   end

   // restart pulse hands the channel back to the sequencer, which applies
   // turn_on_delay and turn_on_rise_time as for any normal turn-on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_restart_o <= '0;
      end else begin
         chan_restart_o <= chan_off & ~next_chan_off;
      end
   end

   assign chan_off_o = chan_off;

   // ---- wishbone classic slave, one wait state
   always_comb begin
      req.cyc = wb_cyc_i;
      req.stb = wb_stb_i;
      req.we = wb_we_i;
      req.sel = wb_sel_i;
      req.adr = wb_adr_i;
      req.dat = wb_dat_i;
   end

   assign word_adr = req.adr & `SFL_ADR_WORD_MASK;
   assign bus_take = req.cyc && req.stb && !wb_ack_o;
   // writes land on the edge where the master sees ack
   assign bus_write = req.cyc && req.stb && req.we && wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_take;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `SFL_NUM_LINES; i++) begin
            shutdown_select[i] <= `SFL_SEL_RESET;
         end
      end else if (bus_write && req.sel[0] && select_index(word_adr) >= 0) begin
         // only the low nibble is stored; the upper nibble is read-only
         shutdown_select[select_index(word_adr)] <= req.dat[`SFL_SEL_W-1:0];
      end
   end

   // write one to clear; a shutdown in the same cycle keeps its bit
   assign status_clear = (bus_write && req.sel[0] && word_adr == `SFL_ADR_STATUS) ?
                         req.dat[`SFL_NUM_CHAN-1:0] : '0;
   assign shut_event = next_chan_off & ~chan_off;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_mfr <= `SFL_STATUS_RESET;
      end else begin
         status_mfr <= (status_mfr & ~status_clear) | shut_event;
      end
   end

   // alert holds low until every latched shutdown has been cleared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alert_out_n_o <= 1'b1;
      end else begin
         alert_out_n_o <= ~|((status_mfr & ~status_clear) | shut_event);
      end
   end

   always_comb begin
      next_rdata = `SFL_DAT_ZERO;
      if (select_index(word_adr) >= 0) begin
         next_rdata[`SFL_SEL_W-1:0] = shutdown_select[select_index(word_adr)];
      end else if (word_adr == `SFL_ADR_STATUS) begin
         next_rdata[`SFL_NUM_CHAN-1:0] = status_mfr;
      end else if (word_adr == `SFL_ADR_LIVE) begin
         next_rdata[`SFL_NUM_CHAN-1:0] = chan_off;
         next_rdata[`SFL_NUM_CHAN +: `SFL_NUM_LINES] = line_held;
         next_rdata[`SFL_NUM_CHAN + `SFL_NUM_LINES +: `SFL_NUM_LINES] = line_low;
      end
   end

   // read data is only meaningful with ack; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= `SFL_DAT_ZERO;
      end else if (bus_take && !req.we) begin
         wb_dat_o <= next_rdata;
      end else begin
         wb_dat_o <= `SFL_DAT_ZERO;
      end
   end

endmodule
`default_nettype wire

/* File: sfl_fault_response_assertions.sv */
// port-level assertions for the shared fault line response block
`timescale 1ns/1ps
`default_nettype none
module sfl_fault_response_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic zone0_fault_line_a_n_i,
   input wire logic zone0_fault_line_b_n_i,
   input wire logic zone1_fault_line_a_n_i,
   input wire logic zone1_fault_line_b_n_i,
   input wire logic [7:0] chan_off_o,
   input wire logic [7:0] chan_restart_o,
   input wire logic alert_out_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_sel_read;
      wb_ack_o && !wb_we_i && wb_adr_i < 8'h10;
   endsequence
   property p_ack; s_req |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_sel_upper; s_sel_read |-> wb_dat_o[31:4] == 28'h0; endproperty
   property p_alert; (chan_off_o & ~$past(chan_off_o)) != 8'h0 |-> !alert_out_n_o; endproperty
   property p_restart; chan_restart_o == ($past(chan_off_o) & ~chan_off_o); endproperty
   // a zone's channels only trip from that zone's own lines, which must have been low six cycles earlier
   property p_zone0;
      (chan_off_o[3:0] & ~$past(chan_off_o[3:0])) != 4'h0
         |-> !$past(zone0_fault_line_a_n_i, 6) || !$past(zone0_fault_line_b_n_i, 6);
   endproperty
   property p_zone1;
      (chan_off_o[7:4] & ~$past(chan_off_o[7:4])) != 4'h0
         |-> !$past(zone1_fault_line_a_n_i, 6) || !$past(zone1_fault_line_b_n_i, 6);
   endproperty
   a_ack: assert property (p_ack) else $error("no ack one cycle after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   a_sel_upper: assert property (p_sel_upper) else $error("select upper bits not zero");
   a_alert: assert property (p_alert) else $error("shutdown without alert");
   a_restart: assert property (p_restart) else $error("restart pulse mismatch");
   a_zone0: assert property (p_zone0) else $error("zone 0 channel off without its line");
   a_zone1: assert property (p_zone1) else $error("zone 1 channel off without its line");
endmodule
bind sfl_fault_response sfl_fault_response_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .zone0_fault_line_a_n_i(zone0_fault_line_a_n_i),
   .zone0_fault_line_b_n_i(zone0_fault_line_b_n_i), .zone1_fault_line_a_n_i(zone1_fault_line_a_n_i),
   .zone1_fault_line_b_n_i(zone1_fault_line_b_n_i), .chan_off_o(chan_off_o),
   .chan_restart_o(chan_restart_o), .alert_out_n_o(alert_out_n_o));
`default_nettype wire

/* File: sfl_peer_model.sv */
// peer managers pulling the shared open-drain fault lines
`timescale 1ns/1ps
`default_nettype none
module sfl_peer_model (
   input wire logic [3:0] pull_i,
   output logic [3:0] line_n_o
);
   // lines carry pull-ups, so a released line reads high
   assign line_n_o = ~pull_i;
endmodule
`default_nettype wire

/* File: sfl_fault_response_test.sv */
// testbench for the shared fault line response block
`timescale 1ns/1ps
`default_nettype none
`include "sfl_cfg.svh"
module sfl_fault_response_test;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, alert_n;
   logic [3:0] sel = 0, pull = 0, lines;
   logic [7:0] adr = 0, off, rs, rs_seen = 0;
   logic [31:0] wdat = 0, dat_o, rd;
   logic [7:0] regs [4] = '{`SFL_ADR_Z0_LINE_A, `SFL_ADR_Z0_LINE_B, `SFL_ADR_Z1_LINE_A, `SFL_ADR_Z1_LINE_B};
   logic [7:0] trip [4] = '{8'h05, 8'h0a, 8'h30, 8'hc0};
   int errors = 0, comparisons = 0;
   always #20 clk_i = ~clk_i;
   always @(negedge clk_i) rs_seen = rs_seen | rs;
   sfl_peer_model u_peer (.pull_i(pull), .line_n_o(lines));
   sfl_fault_response u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .zone0_fault_line_a_n_i(lines[0]), .zone0_fault_line_b_n_i(lines[1]), .zone1_fault_line_a_n_i(lines[2]),
      .zone1_fault_line_b_n_i(lines[3]), .chan_off_o(off), .chan_restart_o(rs), .alert_out_n_o(alert_n));
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      n = 0;
      // ack and data read right after the edge still hold their pre-edge, sampled values
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
         errors++;
         give_verdict();
      end
      rd = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic wait_off(input logic [7:0] exp, input int lim);
      int n;
      n = 0;
      while (off !== exp && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      check("chan_off", {24'h0, off}, {24'h0, exp});
      if (off !== exp) give_verdict();
   endtask
   task automatic t_regs();
      for (int i = 0; i < 4; i++) begin
         bus(0, regs[i], 0, 4'h1);
         check("select reset", rd, 32'h0);
         bus(1, regs[i], 32'hffff_ffff, 4'h1);
         bus(1, regs[i], 32'h0, 4'h0);
         bus(0, regs[i], 0, 4'h1);
         check("select upper", rd, 32'h0f);
      end
      bus(1, 8'h18, 32'hff, 4'hf);
      bus(0, 8'h18, 0, 4'hf);
      check("unmapped", rd, 32'h0);
   endtask
   task automatic t_trips();
      for (int i = 0; i < 4; i++) bus(1, regs[i], {28'h0, i[1] ? trip[i][7:4] : trip[i][3:0]}, 4'h1);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         pull[i] <= 1'b1;
         repeat (240) @(negedge clk_i);
         check("early off", {24'h0, off}, 32'h0);
         wait_off(trip[i], 40);
         check("alert", {31'h0, alert_n}, 32'h0);
         bus(0, `SFL_ADR_STATUS, 0, 4'h1);
         check("status", rd, {24'h0, trip[i]});
         rs_seen = 0;
         @(posedge clk_i);
         pull[i] <= 1'b0;
         wait_off(8'h0, 20);
         @(negedge clk_i);
         check("restart", {24'h0, rs_seen}, {24'h0, trip[i]});
         bus(1, `SFL_ADR_STATUS, 32'hff, 4'h1);
         @(negedge clk_i);
         check("alert clear", {31'h0, alert_n}, 32'h1);
      end
   endtask
   task automatic t_short();
      // two short assertions sum past the interval, so a timer that never restarts would trip
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_i);
         pull[0] <= 1'b1;
         repeat (200) @(posedge clk_i);
         pull[0] <= 1'b0;
         repeat (10) @(posedge clk_i);
      end
      @(negedge clk_i);
      check("short pulse", {24'h0, off}, 32'h0);
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      t_regs();
      t_trips();
      t_short();
      give_verdict();
   end
endmodule
`default_nettype wire
